// ===== logic/pdeg_pkg.sv
`default_nettype none
package pdeg_pkg;
	// ======================================
	// register map (register indices, shifted to byte addresses on apb)
	localparam logic [11:0] PDEG_OFS_PORT_D_DATA      = 12'h003;
	localparam logic [11:0] PDEG_OFS_PORT_E_DATA      = 12'h008;
	localparam logic [11:0] PDEG_OFS_PORT_D_DIRECTION = 12'h007;
	localparam logic [11:0] PDEG_OFS_PORT_E_DIRECTION = 12'h00b;
	localparam logic [11:0] PDEG_OFS_PORT_D_CONTROL   = 12'h00a;
	// ======================================
	// register index scheme: byte address = 4 * index
	localparam int          PDEG_IDX_SHIFT = 2;
	// ======================================
	// widths and reset values
	localparam int          PDEG_D_W     = 8;
	localparam int          PDEG_E_W     = 2;
	localparam logic [7:0]  PDEG_DIR_D_RST = 8'h00;
	localparam logic [1:0]  PDEG_DIR_E_RST = 2'h0;
	localparam logic [3:0]  PDEG_CTRL_RST  = 4'h0;
	// ======================================
	// port d control fields
	localparam int          PDEG_CTRL_SLOW6 = 0;
	localparam int          PDEG_CTRL_SLOW7 = 1;
	localparam int          PDEG_CTRL_PU6   = 2;
	localparam int          PDEG_CTRL_PU7   = 3;
	localparam int          PDEG_CTRL_W     = 4;
	// ======================================
	// converter channel select: port d pins 0..3 carry channels 8..11
	localparam logic [4:0]  PDEG_ADC_CH_BASE = 5'h08;
	localparam int          PDEG_ADC_PINS    = 4;
	// ======================================
	// pin indices
	localparam int          PDEG_PIN_TMR1_CH0 = 4;
	localparam int          PDEG_PIN_TMR1_CH1 = 5;
	localparam int          PDEG_PIN_TXD   = 6;
	localparam int          PDEG_PIN_RXD   = 7;
endpackage : pdeg_pkg
`default_nettype wire

// ===== logic/pdeg_gpio.sv
// Function
// (R1) one software read/write latch per pin, untouched by reset
// (R2) port d direction bit 1 drives pin, reset clears all
// (R3) port e direction bit 1 drives pin, reset clears both
// (R4) port d data read: latch where output, pin where input
// (R5) port e data read: latch where output, pin where input
// (R6) data writes always update latch whatever the direction
// (R7) slow-edge bit makes pin 6 or 7 open-drain sink, direction kept
// (R8) pull-up bit connects pull-up on pin 6 or 7 regardless of direction
// (R9) converter channel select on a port d pin overrides port logic
// (R10) timer 1 edge/level select hands pins d4, d5 to timer
// (R11) timer 2 edge/level select hands pins e0, e1 to timer
// (R12) serial enable makes d6 transmit, d7 receive, overriding port logic
// (R13) software loads port d latch before setting a direction bit
// (R14) software loads port e latch before setting a direction bit
// (R15) accesses complete in one cycle, pins follow at next edge
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pdeg_gpio
	import pdeg_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                arst_n_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [11:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire logic [PDEG_D_W-1:0] port_d_pin_i,
	output logic      [PDEG_D_W-1:0] port_d_pin_o,
	output logic      [PDEG_D_W-1:0] port_d_pin_oe_o,
	output logic      [1:0]          port_d_pullup_o,
	output logic      [1:0]          port_d_sink_o,
	input  wire logic [PDEG_E_W-1:0] port_e_pin_i,
	output logic      [PDEG_E_W-1:0] port_e_pin_o,
	output logic      [PDEG_E_W-1:0] port_e_pin_oe_o,
	input  wire logic [4:0]          converter_channel_select_i,
	input  wire logic                converter_enable_i,
	input  wire logic [1:0]          timer1_channel_enable_i,
	input  wire logic [1:0]          timer1_channel_out_i,
	input  wire logic [1:0]          timer1_channel_oe_i,
	output logic      [1:0]          timer1_channel_in_o,
	input  wire logic [1:0]          timer2_channel_enable_i,
	input  wire logic [1:0]          timer2_channel_out_i,
	input  wire logic [1:0]          timer2_channel_oe_i,
	output logic      [1:0]          timer2_channel_in_o,
	input  wire logic                serial_interface_enable_i,
	input  wire logic                serial_tx_i,
	output logic                     serial_rx_o
);

	// ======================================
	// bus decode
	logic                   wr_en;
	logic                   rd_en;
	logic                   sel_d_data;
	logic                   sel_e_data;
	logic                   sel_d_dir;
	logic                   sel_e_dir;
	logic                   sel_d_ctrl;
	logic                   hit;
	logic [PDEG_D_W-1:0]    port_d_latch_r;
	logic [PDEG_E_W-1:0]    port_e_latch_r;
	logic [PDEG_D_W-1:0]    port_d_direction_r;
	logic [PDEG_E_W-1:0]    port_e_direction_r;
	logic [PDEG_CTRL_W-1:0] port_d_control_r;
	logic [31:0]            rdata_nxt;
	logic [PDEG_D_W-1:0]    d_read;
	logic [PDEG_E_W-1:0]    e_read;

	// single-cycle access: pready high after reset, writes count in the access phase, reads in the setup phase
	assign wr_en      = psel_i & penable_i & pwrite_i; // (R15)
	assign rd_en      = psel_i & ~penable_i & ~pwrite_i;
	assign sel_d_data = (paddr_i == (PDEG_OFS_PORT_D_DATA << PDEG_IDX_SHIFT));
	assign sel_e_data = (paddr_i == (PDEG_OFS_PORT_E_DATA << PDEG_IDX_SHIFT));
	assign sel_d_dir  = (paddr_i == (PDEG_OFS_PORT_D_DIRECTION << PDEG_IDX_SHIFT));
	assign sel_e_dir  = (paddr_i == (PDEG_OFS_PORT_E_DIRECTION << PDEG_IDX_SHIFT));
	assign sel_d_ctrl = (paddr_i == (PDEG_OFS_PORT_D_CONTROL << PDEG_IDX_SHIFT));
	assign hit        = sel_d_data | sel_e_data | sel_d_dir | sel_e_dir | sel_d_ctrl;

	// ======================================
	// data latches: no reset, power-up contents are undefined by design
	always_ff @(posedge clk_sys_i) begin
		if (wr_en && sel_d_data) begin
			port_d_latch_r <= pwdata_i[PDEG_D_W-1:0]; // (R1) (R6)
		end
		if (wr_en && sel_e_data) begin
			port_e_latch_r <= pwdata_i[PDEG_E_W-1:0]; // (R1) (R6)
		end
	end

	// ======================================
	// direction and control
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_d_direction_r <= PDEG_DIR_D_RST; // (R2)
			port_e_direction_r <= PDEG_DIR_E_RST; // (R3)
			port_d_control_r   <= PDEG_CTRL_RST;
		end else begin
			if (wr_en && sel_d_dir) begin
				port_d_direction_r <= pwdata_i[PDEG_D_W-1:0]; // (R2)
			end
			if (wr_en && sel_e_dir) begin
				port_e_direction_r <= pwdata_i[PDEG_E_W-1:0]; // (R3)
			end
			if (wr_en && sel_d_ctrl) begin
				port_d_control_r <= pwdata_i[PDEG_CTRL_W-1:0];
			end
		end
	end

	// ======================================
	// read mux; data sampled in setup, presented in access phase
	assign d_read = (port_d_direction_r & port_d_latch_r) | (~port_d_direction_r & port_d_pin_i); // (R4)
	assign e_read = (port_e_direction_r & port_e_latch_r) | (~port_e_direction_r & port_e_pin_i); // (R5)

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (sel_d_data) begin
			rdata_nxt[PDEG_D_W-1:0] = d_read; // (R4)
		end else if (sel_e_data) begin
			rdata_nxt[PDEG_E_W-1:0] = e_read; // (R5)
		end else if (sel_d_dir) begin
			rdata_nxt[PDEG_D_W-1:0] = port_d_direction_r;
		end else if (sel_e_dir) begin
			rdata_nxt[PDEG_E_W-1:0] = port_e_direction_r;
		end else if (sel_d_ctrl) begin
			rdata_nxt[PDEG_CTRL_W-1:0] = port_d_control_r;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= 1'b1; // (R15)
			pslverr_o <= psel_i & ~penable_i & ~hit;
			if (rd_en) begin
				prdata_o <= rdata_nxt;
			end
		end
	end

	// ======================================
	// pin muxing; peripheral owners override port logic
	logic [PDEG_D_W-1:0] d_out_nxt;
	logic [PDEG_D_W-1:0] d_oe_nxt;
	logic [PDEG_E_W-1:0] e_out_nxt;
	logic [PDEG_E_W-1:0] e_oe_nxt;
	logic [4:0]          adc_off;

	assign adc_off = converter_channel_select_i - PDEG_ADC_CH_BASE;

	always_comb begin
		d_out_nxt = port_d_latch_r;
		d_oe_nxt  = port_d_direction_r; // (R2)
		e_out_nxt = port_e_latch_r;
		e_oe_nxt  = port_e_direction_r; // (R3)
		// open drain: drive only the low level, release otherwise
		if (port_d_control_r[PDEG_CTRL_SLOW6]) begin
			d_oe_nxt[PDEG_PIN_TXD] = port_d_direction_r[PDEG_PIN_TXD] & ~port_d_latch_r[PDEG_PIN_TXD]; // (R7)
		end
		if (port_d_control_r[PDEG_CTRL_SLOW7]) begin
			d_oe_nxt[PDEG_PIN_RXD] = port_d_direction_r[PDEG_PIN_RXD] & ~port_d_latch_r[PDEG_PIN_RXD]; // (R7)
		end
		if (timer1_channel_enable_i[0]) begin
			d_out_nxt[PDEG_PIN_TMR1_CH0] = timer1_channel_out_i[0]; // (R10)
			d_oe_nxt[PDEG_PIN_TMR1_CH0]  = timer1_channel_oe_i[0];
		end
		if (timer1_channel_enable_i[1]) begin
			d_out_nxt[PDEG_PIN_TMR1_CH1] = timer1_channel_out_i[1]; // (R10)
			d_oe_nxt[PDEG_PIN_TMR1_CH1]  = timer1_channel_oe_i[1];
		end
		if (serial_interface_enable_i) begin
			d_out_nxt[PDEG_PIN_TXD] = serial_tx_i; // (R12)
			d_oe_nxt[PDEG_PIN_TXD]  = 1'b1;
			d_oe_nxt[PDEG_PIN_RXD]  = 1'b0;
		end
		// analog input wins: buffer off on the selected pin
		if (converter_enable_i && (converter_channel_select_i >= PDEG_ADC_CH_BASE)
				&& (adc_off < 5'(PDEG_ADC_PINS))) begin
			d_oe_nxt[adc_off[1:0]] = 1'b0; // (R9)
		end
		for (int i = 0; i < PDEG_E_W; i++) begin
			if (timer2_channel_enable_i[i]) begin
				e_out_nxt[i] = timer2_channel_out_i[i]; // (R11)
				e_oe_nxt[i]  = timer2_channel_oe_i[i];
			end
		end
	end

	// registered pins: a write shows at the pins one edge after it is taken
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_d_pin_o        <= 8'h00;
			port_d_pin_oe_o     <= 8'h00;
			port_e_pin_o        <= 2'h0;
			port_e_pin_oe_o     <= 2'h0;
			port_d_pullup_o     <= 2'h0;
			port_d_sink_o       <= 2'h0;
			timer1_channel_in_o <= 2'h0;
			timer2_channel_in_o <= 2'h0;
			serial_rx_o         <= 1'b0;
		end else begin
			port_d_pin_o        <= d_out_nxt; // (R15)
			port_d_pin_oe_o     <= d_oe_nxt;
			port_e_pin_o        <= e_out_nxt;
			port_e_pin_oe_o     <= e_oe_nxt;
			port_d_pullup_o     <= {port_d_control_r[PDEG_CTRL_PU7], port_d_control_r[PDEG_CTRL_PU6]}; // (R8)
			port_d_sink_o       <= {port_d_control_r[PDEG_CTRL_SLOW7], port_d_control_r[PDEG_CTRL_SLOW6]}; // (R7)
			timer1_channel_in_o <= port_d_pin_i[PDEG_PIN_TMR1_CH1:PDEG_PIN_TMR1_CH0]; // (R10)
			timer2_channel_in_o <= port_e_pin_i; // (R11)
			serial_rx_o         <= port_d_pin_i[PDEG_PIN_RXD]; // (R12)
		end
	end

	// ======================================
	// checks
	property p_dir_d_write;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_en && sel_d_dir) |=> (port_d_direction_r == $past(pwdata_i[PDEG_D_W-1:0]));
	endproperty
	a_dir_d_write: assert property (p_dir_d_write) else $error("port d direction write lost"); // (R2)

	property p_dir_e_write;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_en && sel_e_dir) |=> (port_e_direction_r == $past(pwdata_i[PDEG_E_W-1:0]));
	endproperty
	a_dir_e_write: assert property (p_dir_e_write) else $error("port e direction write lost"); // (R3)

	property p_read_d;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(rd_en && sel_d_data) |=> (prdata_o[PDEG_D_W-1:0] == $past(d_read));
	endproperty
	a_read_d: assert property (p_read_d) else $error("port d read mismatch"); // (R4)

	property p_read_e;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(rd_en && sel_e_data) |=> (prdata_o[PDEG_E_W-1:0] == $past(e_read));
	endproperty
	a_read_e: assert property (p_read_e) else $error("port e read mismatch"); // (R5)

	sequence s_d_data_write;
		wr_en && sel_d_data;
	endsequence
	property p_latch_write;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_d_data_write |=> (port_d_latch_r == $past(pwdata_i[PDEG_D_W-1:0]));
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("port d latch not written"); // (R6)

	property p_pins_follow;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_d_data_write ##1 (port_d_direction_r == 8'hff && port_d_control_r == 4'h0
			&& !serial_interface_enable_i && !converter_enable_i
			&& timer1_channel_enable_i == 2'h0)
			|=> (port_d_pin_o == $past(pwdata_i[PDEG_D_W-1:0], 2));
	endproperty
	a_pins_follow: assert property (p_pins_follow) else $error("pins did not follow write"); // (R15)

	property p_serial_tx;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		serial_interface_enable_i && !converter_enable_i
			|=> port_d_pin_oe_o[PDEG_PIN_TXD] && !port_d_pin_oe_o[PDEG_PIN_RXD];
	endproperty
	a_serial_tx: assert property (p_serial_tx) else $error("serial pins not taken over"); // (R12)

	property p_open_drain;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		port_d_control_r[PDEG_CTRL_SLOW6] && port_d_latch_r[PDEG_PIN_TXD]
			&& !serial_interface_enable_i |=> !port_d_pin_oe_o[PDEG_PIN_TXD];
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // (R7)

	property p_pullup;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		1'b1 |=> port_d_pullup_o == $past({port_d_control_r[PDEG_CTRL_PU7],
			port_d_control_r[PDEG_CTRL_PU6]});
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not per control"); // (R8)

	property p_adc;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		converter_enable_i && converter_channel_select_i == PDEG_ADC_CH_BASE
			|=> !port_d_pin_oe_o[0];
	endproperty
	a_adc: assert property (p_adc) else $error("converter pin still driven"); // (R9)

	property p_timer2;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(timer2_channel_enable_i != 2'h0) |=> ((port_e_pin_o ^ $past(timer2_channel_out_i))
			& $past(timer2_channel_enable_i)) == 2'h0;
	endproperty
	a_timer2: assert property (p_timer2) else $error("timer 2 pin not taken over"); // (R11)

	property p_timer1;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(timer1_channel_enable_i != 2'h0) |=> ((port_d_pin_o[PDEG_PIN_TMR1_CH1:PDEG_PIN_TMR1_CH0]
			^ $past(timer1_channel_out_i)) & $past(timer1_channel_enable_i)) == 2'h0;
	endproperty
	a_timer1: assert property (p_timer1) else $error("timer 1 pin not taken over"); // (R10)

	// zero wait states: every access phase completes at its first edge
	property p_zero_wait;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		psel_i && penable_i |-> pready_o;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("access phase stalled"); // (R15)

	sequence s_setup_unmapped;
		psel_i && !penable_i && !hit;
	endsequence
	property p_unmapped_err;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_setup_unmapped |=> pslverr_o;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused"); // (R15)

	property p_unmapped_read;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		rd_en && !hit |=> prdata_o == 32'h0000_0000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // (R15)

	// read data must stand through the access phase and beyond
	property p_rdata_hold;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		!rd_en |=> $stable(prdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed outside a read"); // (R15)

	property p_latch_e_write;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_en && sel_e_data) |=> (port_e_latch_r == $past(pwdata_i[PDEG_E_W-1:0]));
	endproperty
	a_latch_e_write: assert property (p_latch_e_write) else $error("port e latch not written"); // (R6)

	property p_sink;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		1'b1 |=> port_d_sink_o == $past({port_d_control_r[PDEG_CTRL_SLOW7],
			port_d_control_r[PDEG_CTRL_SLOW6]});
	endproperty
	a_sink: assert property (p_sink) else $error("sink mode not per control"); // (R7)

endmodule // pdeg_gpio
`default_nettype wire

// ===== testbench/pdeg_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ======================================
// pads: chip drivers, pull-ups, outside sources
module pdeg_pin_model
	import pdeg_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic [PDEG_D_W-1:0] d_o_i,
	input  wire logic [PDEG_D_W-1:0] d_oe_i,
	input  wire logic [1:0]          d_pu_i,
	input  wire logic [1:0]          d_sink_i,
	input  wire logic [PDEG_D_W-1:0] d_ext_i,
	input  wire logic [PDEG_D_W-1:0] d_ext_en_i,
	input  wire logic [PDEG_E_W-1:0] e_o_i,
	input  wire logic [PDEG_E_W-1:0] e_oe_i,
	input  wire logic [PDEG_E_W-1:0] e_ext_i,
	output logic      [PDEG_D_W-1:0] d_lvl_o,
	output logic      [PDEG_E_W-1:0] e_lvl_o
);
	logic [PDEG_D_W-1:0] float_r = 8'h55;
	logic [PDEG_D_W-1:0] drv;
	logic [PDEG_D_W-1:0] pu;
	// undriven pins wander, so a stale level never reads as valid
	always_ff @(posedge clk_sys_i) float_r <= ~float_r;
	// open drain: a high from a sinking pin is a release
	assign drv = d_oe_i & ~({d_sink_i, 6'h00} & d_o_i);
	assign pu = {d_pu_i, 6'h00};
	assign d_lvl_o = (drv & d_o_i) | (~drv & d_ext_en_i & d_ext_i)
		| (~drv & ~d_ext_en_i & (pu | float_r));
	assign e_lvl_o = (e_oe_i & e_o_i) | (~e_oe_i & e_ext_i);
endmodule // pdeg_pin_model
`default_nettype wire

// ===== testbench/port_d_e_gpio_tb.sv
`timescale 1ns/10ps
`default_nettype none
module port_d_e_gpio_tb
	import pdeg_pkg::*;
;
	localparam logic [11:0] A_DD = PDEG_OFS_PORT_D_DATA << PDEG_IDX_SHIFT;
	localparam logic [11:0] A_ED = PDEG_OFS_PORT_E_DATA << PDEG_IDX_SHIFT;
	localparam logic [11:0] A_DR = PDEG_OFS_PORT_D_DIRECTION << PDEG_IDX_SHIFT;
	localparam logic [11:0] A_ER = PDEG_OFS_PORT_E_DIRECTION << PDEG_IDX_SHIFT;
	localparam logic [11:0] A_DC = PDEG_OFS_PORT_D_CONTROL << PDEG_IDX_SHIFT;
	logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [7:0]  d_lvl, d_o, d_oe, d_ext, d_ext_en;
	logic [1:0]  pu, sink, e_lvl, e_o, e_oe, e_ext;
	logic [1:0]  t1en, t1out, t1oe, t1in, t2en, t2out, t2oe, t2in;
	logic [4:0]  cch;
	logic        cen, sen, stx, srx;
	int          mismatches, n_tests;
	pdeg_gpio dut (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .port_d_pin_i(d_lvl), .port_d_pin_o(d_o),
		.port_d_pin_oe_o(d_oe), .port_d_pullup_o(pu), .port_d_sink_o(sink),
		.port_e_pin_i(e_lvl), .port_e_pin_o(e_o), .port_e_pin_oe_o(e_oe),
		.converter_channel_select_i(cch), .converter_enable_i(cen),
		.timer1_channel_enable_i(t1en), .timer1_channel_out_i(t1out),
		.timer1_channel_oe_i(t1oe), .timer1_channel_in_o(t1in),
		.timer2_channel_enable_i(t2en), .timer2_channel_out_i(t2out),
		.timer2_channel_oe_i(t2oe), .timer2_channel_in_o(t2in),
		.serial_interface_enable_i(sen), .serial_tx_i(stx), .serial_rx_o(srx));
	pdeg_pin_model pads (.clk_sys_i(clk_sys), .d_o_i(d_o), .d_oe_i(d_oe), .d_pu_i(pu),
		.d_sink_i(sink), .d_ext_i(d_ext), .d_ext_en_i(d_ext_en), .e_o_i(e_o), .e_oe_i(e_oe),
		.e_ext_i(e_ext), .d_lvl_o(d_lvl), .e_lvl_o(e_lvl));
	// ======================================
	// bus, compare and closing tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask
	// pins lag the register by one edge; extra edges give margin
	task automatic settle();
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ======================================
	// clock, watchdog, tests
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		print_verdict();
	end
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata, cch, cen, sen, stx} = '0;
		{t1en, t1out, t1oe, t2en, t2out, t2oe} = '0;
		d_ext = 8'h3c;
		d_ext_en = 8'hff;
		e_ext = 2'b01;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		chk(d_oe, 8'h00);
		apb(1'b0, A_DR, 0);
		chk(rdv, 0);
		apb(1'b0, A_ER, 0);
		chk(rdv, 0);
		apb(1'b0, 12'h040, 0);
		chk({rdv[30:0], err}, 1);
		apb(1'b1, A_DD, 32'ha5);
		apb(1'b1, A_DR, 32'h0f);
		settle();
		chk({d_oe, d_o & 8'h0f}, 16'h0f05);
		apb(1'b0, A_DD, 0);
		chk(rdv, 32'h35);
		apb(1'b1, A_DD, 32'hff);
		apb(1'b0, A_DD, 0);
		chk(rdv, 32'h3f);
		apb(1'b1, A_ED, 32'h2);
		apb(1'b1, A_ER, 32'h1);
		settle();
		chk(e_oe, 2'b01);
		apb(1'b0, A_ED, 0);
		chk(rdv, 0);
		apb(1'b1, A_DC, 32'h5);
		settle();
		chk({sink, pu}, 4'b0101);
		apb(1'b1, A_DR, 32'hcf);
		apb(1'b1, A_DC, 32'ha);
		apb(1'b0, A_DC, 0);
		chk(rdv, 32'ha);
		apb(1'b0, A_DR, 0);
		chk(rdv, 32'hcf);
		settle();
		chk({sink, pu}, 4'b1010);
		d_ext <= 8'hbc;
		d_ext_en <= 8'h30;
		sen <= 1'b1;
		settle();
		// d7 released and pulled up, so the receive path must see a one
		chk({d_oe[7:6], d_o[6], srx}, 4'b0101);
		sen <= 1'b0;
		t1en <= 2'b01;
		t1oe <= 2'b01;
		t1out <= 2'b01;
		settle();
		chk({d_oe[5:4], d_o[4], t1in}, 5'b01111);
		t1en <= 2'b00;
		t2en <= 2'b10;
		t2oe <= 2'b10;
		t2out <= 2'b10;
		settle();
		chk({e_oe, e_o[1], t2in}, 5'b11110);
		t2en <= 2'b00;
		cen <= 1'b1;
		// d7 is open drain with latch high, so its driver stays off
		for (int i = 0; i < PDEG_ADC_PINS; i++) begin
			cch <= PDEG_ADC_CH_BASE + 5'(i);
			settle();
			chk(d_oe, 8'h4f & ~(8'h01 << i));
		end
		cen <= 1'b0;
		arst_n <= 1'b0;
		settle();
		arst_n <= 1'b1;
		chk({d_oe, e_oe}, 0);
		apb(1'b1, A_DR, 32'hff);
		apb(1'b1, A_ER, 32'h3);
		apb(1'b0, A_DD, 0);
		chk(rdv, 32'hff);
		apb(1'b0, A_ED, 0);
		chk(rdv, 32'h2);
		apb(1'b1, A_DD, 32'h5a);
		@(negedge clk_sys);
		chk(d_o, 8'hff);
		@(negedge clk_sys);
		chk(d_o, 8'h5a);
		print_verdict();
	end
endmodule // port_d_e_gpio_tb
`default_nettype wire
